// *** rtl/adc_ctrl_pkg.sv ***
package adc_ctrl_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam logic [2:0] OFF_CONTROL_STATUS_A = 3'h0;
  localparam logic [2:0] OFF_CONTROL_STATUS_B = 3'h1;
  localparam logic [2:0] OFF_RESULT_LOW       = 3'h2;
  localparam logic [2:0] OFF_RESULT_HIGH      = 3'h3;
  localparam logic [2:0] OFF_RESULT_CONFIG    = 3'h4;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned A_ENABLE_BIT     = 7;
  localparam int unsigned A_START_BIT      = 6;
  localparam int unsigned A_AUTO_BIT       = 5;
  localparam int unsigned A_FLAG_BIT       = 4;
  localparam int unsigned A_IRQ_EN_BIT     = 3;
  localparam int unsigned A_DIV_LSB        = 0;
  localparam int unsigned DIV_SEL_W        = 3;
  localparam int unsigned B_HIGH_SPEED_BIT = 7;
  localparam int unsigned B_TRIG_LSB       = 0;
  localparam int unsigned TRIG_SEL_W       = 4;
  localparam int unsigned CFG_LEFT_ADJ_BIT = 5;

  // ****************************************************************
  // Reset values and widths
  // ****************************************************************
  localparam logic [7:0] RST_CONTROL_STATUS_A = 8'h00;
  localparam logic [7:0] RST_CONTROL_STATUS_B = 8'h00;
  localparam logic [7:0] RST_RESULT_CONFIG    = 8'h00;
  localparam logic [9:0] RST_RESULT           = 10'h000;
  localparam int unsigned RESULT_W            = 10;
  localparam int unsigned DIV_CNT_W           = 7;
  localparam logic [6:0] RST_DIV_CNT          = 7'h00;

  // ****************************************************************
  // Trigger source codes
  // ****************************************************************
  localparam logic [3:0] TRIG_FREE_RUN   = 4'h0;
  localparam logic [3:0] TRIG_COMP0      = 4'h1;
  localparam logic [3:0] TRIG_EXT_INT0   = 4'h2;
  localparam logic [3:0] TRIG_T0_COMPARE = 4'h3;
  localparam logic [3:0] TRIG_T0_OVF     = 4'h4;
  localparam logic [3:0] TRIG_T1_CMP_B   = 4'h5;
  localparam logic [3:0] TRIG_T1_OVF     = 4'h6;
  localparam logic [3:0] TRIG_T1_CAPTURE = 4'h7;
  localparam logic [3:0] TRIG_STAGE0     = 4'h8;
  localparam logic [3:0] TRIG_STAGE2     = 4'ha;
  localparam logic [3:0] TRIG_COMP1      = 4'hb;
  localparam logic [3:0] TRIG_COMP2      = 4'hc;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } conv_st_t;

endpackage

// *** rtl/converter_clock_divider.sv ***
`timescale 1ns/1ps
module converter_clock_divider
(
  input  wire logic                                ref_clk,
  input  wire logic                                reset_n,
  input  wire logic [adc_ctrl_pkg::DIV_SEL_W-1:0] div_sel,
  output logic                                     converter_clk
);
  import adc_ctrl_pkg::*;

  typedef struct packed {
    logic [DIV_CNT_W-1:0] cnt;
    logic                 clk;
  } div_state_t;

  div_state_t d_q;
  div_state_t d_d;
  logic [DIV_CNT_W-1:0] half;

  // ****************************************************************
  // Half period: codes 0 and 1 both give divide by 2
  // ****************************************************************
  always_comb
  begin
    if (div_sel < 3'h2)
    begin
      half = 7'h01;
    end
    else
    begin
      half = DIV_CNT_W'(7'h01 << (div_sel - 3'h1));
    end
    d_d = d_q;
    if (d_q.cnt >= half - 7'h01)
    begin
      d_d.cnt = RST_DIV_CNT;
      d_d.clk = ~d_q.clk;
    end
    else
    begin
      d_d.cnt = d_q.cnt + 7'h01;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      d_q <= '0;
    end
    else
    begin
      d_q <= d_d;
    end
  end

  assign converter_clk = d_q.clk;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_div_by_two: assert property (
    ($stable(div_sel) && div_sel < 3'h2 && $past(div_sel) < 3'h2)
      |=> (converter_clk != $past(converter_clk)))
    else $error("divide by two clock did not toggle");

  a_div_by_eight: assert property (
    (div_sel == 3'h3) [*8] ##0 $rose(converter_clk)
      |-> (converter_clk [*4]) ##1 !converter_clk)
    else $error("divide by eight clock half period wrong");

endmodule // converter_clock_divider

// *** rtl/adc_trigger_and_result_control.sv ***
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module adc_trigger_and_result_control
(
  input  wire logic                               ref_clk,
  input  wire logic                               reset_n,
  input  wire logic [adc_ctrl_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [adc_ctrl_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                               reg_wr,
  input  wire logic                               reg_rd,
  output logic      [adc_ctrl_pkg::DATA_W-1:0]    reg_rdata,
  input  wire logic                               irq_ack,
  input  wire logic                               amplified_channel,
  input  wire logic                               comp0_flag,
  input  wire logic                               ext_int0_flag,
  input  wire logic                               t0_compare_flag,
  input  wire logic                               t0_overflow_flag,
  input  wire logic                               t1_compare_b_flag,
  input  wire logic                               t1_overflow_flag,
  input  wire logic                               t1_capture_flag,
  input  wire logic                               comp1_flag,
  input  wire logic                               comp2_flag,
  input  wire logic                               stage0_async_event,
  input  wire logic                               stage2_async_event,
  input  wire logic                               conv_done,
  input  wire logic [adc_ctrl_pkg::RESULT_W-1:0]  conv_data,
  output logic                                    conv_start,
  output logic                                    converter_clk,
  output logic                                    high_speed_conversion,
  output logic                                    conversion_irq
);
  import adc_ctrl_pkg::*;

  typedef struct packed {
    logic                  enable;
    logic                  start;
    logic                  auto_trigger_enable;
    logic                  conversion_complete_flag;
    logic                  conversion_irq_enable;
    logic [DIV_SEL_W-1:0]  converter_clock_divider;
    logic                  high_speed;
    logic [TRIG_SEL_W-1:0] trigger_source_select;
    logic                  left_adjust_result;
    logic                  locked;
    logic [RESULT_W-1:0]   result;
    logic [15:0]           flags_prev;
    conv_st_t              st;
    logic                  start_pulse;
    logic                  irq;
    logic [DATA_W-1:0]     rdata;
  } ctrl_state_t;

  ctrl_state_t s_q;
  ctrl_state_t s_d;

  logic [15:0] src_flags;
  logic [15:0] src_rise;
  logic        code_valid;
  logic        trig;
  logic        done_evt;
  logic        wr_a;
  logic        wr_b;
  logic [7:0]  res_high;
  logic [7:0]  res_low;

  // ****************************************************************
  // Event sources indexed by trigger code
  // ****************************************************************
  assign src_flags = {3'h0, comp2_flag, comp1_flag, 1'b0, 1'b0, 1'b0,
                      t1_capture_flag, t1_overflow_flag, t1_compare_b_flag,
                      t0_overflow_flag, t0_compare_flag, ext_int0_flag,
                      comp0_flag, 1'b0};

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_edge
      assign src_rise[gi] = src_flags[gi] & ~s_q.flags_prev[gi];
    end
  endgenerate

  assign done_evt = (s_q.st == ST_CONV) && conv_done;
  assign wr_a     = reg_wr && (reg_addr == OFF_CONTROL_STATUS_A);
  assign wr_b     = reg_wr && (reg_addr == OFF_CONTROL_STATUS_B);

  // ****************************************************************
  // Trigger code check and selection
  // ****************************************************************
  always_comb
  begin
    if (amplified_channel)
    begin
      code_valid = (s_q.trigger_source_select == TRIG_FREE_RUN) ||
                   (s_q.trigger_source_select == TRIG_STAGE0) ||
                   (s_q.trigger_source_select == TRIG_STAGE2);
    end
    else
    begin
      code_valid = (s_q.trigger_source_select <= TRIG_STAGE0) ||
                   (s_q.trigger_source_select == TRIG_STAGE2) ||
                   (s_q.trigger_source_select == TRIG_COMP1) ||
                   (s_q.trigger_source_select == TRIG_COMP2);
    end
    trig = 1'b0;
    if (s_q.auto_trigger_enable && code_valid)
    begin
      case (s_q.trigger_source_select)
        TRIG_FREE_RUN: trig = done_evt;
        TRIG_STAGE0:   trig = stage0_async_event && (s_q.st == ST_IDLE);
        TRIG_STAGE2:   trig = stage2_async_event && (s_q.st == ST_IDLE);
        default:       trig = src_rise[s_q.trigger_source_select];
      endcase
    end
  end

  // ****************************************************************
  // Result view, alignment applied at read time
  // ****************************************************************
  always_comb
  begin
    if (s_q.left_adjust_result)
    begin
      res_high = s_q.result[9:2];
      res_low  = {s_q.result[1:0], 6'h00};
    end
    else
    begin
      res_high = {6'h00, s_q.result[9:8]};
      res_low  = s_q.result[7:0];
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    s_d             = s_q;
    s_d.flags_prev  = src_flags;
    s_d.start_pulse = 1'b0;
    s_d.rdata       = 8'h00;

    if (wr_a)
    begin
      s_d.enable                  = reg_wdata[A_ENABLE_BIT];
      s_d.auto_trigger_enable     = reg_wdata[A_AUTO_BIT];
      s_d.conversion_irq_enable   = reg_wdata[A_IRQ_EN_BIT];
      s_d.converter_clock_divider = reg_wdata[A_DIV_LSB +: DIV_SEL_W];
      if (reg_wdata[A_FLAG_BIT])
      begin
        s_d.conversion_complete_flag = 1'b0;
      end
    end
    if (wr_b)
    begin
      s_d.high_speed            = reg_wdata[B_HIGH_SPEED_BIT];
      s_d.trigger_source_select = reg_wdata[B_TRIG_LSB +: TRIG_SEL_W];
    end
    if (reg_wr && (reg_addr == OFF_RESULT_CONFIG))
    begin
      s_d.left_adjust_result = reg_wdata[CFG_LEFT_ADJ_BIT];
    end
    if (irq_ack)
    begin
      s_d.conversion_complete_flag = 1'b0;
    end

    // Conversion sequencing
    case (s_q.st)
      ST_IDLE:
      begin
        if (s_q.start && s_q.enable)
        begin
          s_d.start_pulse = 1'b1;
          s_d.st          = ST_CONV;
        end
      end
      ST_CONV:
      begin
        if (conv_done)
        begin
          s_d.st    = ST_IDLE;
          s_d.start = 1'b0;
          if (!s_q.locked)
          begin
            s_d.result                   = conv_data;
            s_d.conversion_complete_flag = 1'b1;
          end
        end
      end
      default:
      begin
        s_d.st = ST_IDLE;
      end
    endcase

    // Start requests win over the completion clear
    if (wr_a && reg_wdata[A_START_BIT])
    begin
      s_d.start = 1'b1;
    end
    if (trig)
    begin
      s_d.start = 1'b1;
    end

    // Reads and result lock
    if (reg_rd)
    begin
      case (reg_addr)
        OFF_CONTROL_STATUS_A: s_d.rdata = {s_q.enable, s_q.start, s_q.auto_trigger_enable,
                                           s_q.conversion_complete_flag,
                                           s_q.conversion_irq_enable,
                                           s_q.converter_clock_divider};
        OFF_CONTROL_STATUS_B: s_d.rdata = {s_q.high_speed, 3'h0, s_q.trigger_source_select};
        OFF_RESULT_LOW:
        begin
          s_d.rdata  = res_low;
          s_d.locked = 1'b1;
        end
        OFF_RESULT_HIGH:
        begin
          s_d.rdata  = res_high;
          s_d.locked = 1'b0;
        end
        OFF_RESULT_CONFIG:    s_d.rdata = {2'h0, s_q.left_adjust_result, 5'h00};
        default:              s_d.rdata = 8'h00;
      endcase
    end

    s_d.irq = s_d.conversion_irq_enable && s_d.conversion_complete_flag;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Converter clock
  // ****************************************************************
  converter_clock_divider u_div
  (
    .ref_clk       (ref_clk),
    .reset_n       (reset_n),
    .div_sel       (s_q.converter_clock_divider),
    .converter_clk (converter_clk)
  );

  assign reg_rdata             = s_q.rdata;
  assign conv_start            = s_q.start_pulse;
  assign high_speed_conversion = s_q.high_speed;
  assign conversion_irq        = s_q.irq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence seq_stage0_req;
    s_q.auto_trigger_enable && s_q.enable && s_q.trigger_source_select == TRIG_STAGE0 &&
    stage0_async_event && s_q.st == ST_IDLE && !s_q.start;
  endsequence

  sequence seq_start_then_pulse;
    s_q.start ##1 conv_start;
  endsequence

  a_irq_gating: assert property (
    conversion_irq == (s_q.conversion_irq_enable && s_q.conversion_complete_flag))
    else $error("interrupt request not equal to enable and flag");

  a_flag_on_done: assert property (
    (done_evt && !s_q.locked) |=> s_q.conversion_complete_flag &&
      s_q.result == $past(conv_data))
    else $error("flag or result missing after completion");

  a_flag_ack_clear: assert property (
    (irq_ack && !done_evt) |=> !s_q.conversion_complete_flag)
    else $error("flag not cleared by vector execution");

  a_flag_write_zero: assert property (
    (wr_a && !reg_wdata[A_FLAG_BIT] && !irq_ack && s_q.conversion_complete_flag)
      |=> s_q.conversion_complete_flag)
    else $error("writing zero cleared the flag");

  a_flag_write_one: assert property (
    (wr_a && reg_wdata[A_FLAG_BIT] && !done_evt) |=> !s_q.conversion_complete_flag)
    else $error("writing one did not clear the flag");

  a_lock_hold: assert property (
    (s_q.locked && !(reg_rd && reg_addr == OFF_RESULT_HIGH)) |=> $stable(s_q.result))
    else $error("result changed while locked");

  a_start_clears: assert property (
    (done_evt && !s_q.auto_trigger_enable && !wr_a) |=> !s_q.start)
    else $error("start bit not cleared at completion");

  a_single_ignores: assert property (
    (!s_q.auto_trigger_enable && !s_q.start && !wr_a) |=> !s_q.start)
    else $error("conversion started without request in single mode");

  a_reserved_code: assert property (
    (s_q.auto_trigger_enable && !code_valid && !s_q.start && !wr_a) |=> !s_q.start)
    else $error("reserved trigger code started a conversion");

  a_edge_start: assert property (
    (s_q.auto_trigger_enable && code_valid && s_q.trigger_source_select != TRIG_FREE_RUN &&
     s_q.trigger_source_select != TRIG_STAGE0 && s_q.trigger_source_select != TRIG_STAGE2 &&
     src_rise[s_q.trigger_source_select]) |=> s_q.start)
    else $error("rising event edge did not request conversion");

  a_stage_start: assert property (
    seq_stage0_req |=> seq_start_then_pulse)
    else $error("stage event did not start a conversion");

  a_high_speed: assert property (
    wr_b |=> high_speed_conversion == $past(reg_wdata[B_HIGH_SPEED_BIT]))
    else $error("high speed bit not taken");

endmodule // adc_trigger_and_result_control

// *** verification/event_source_model.sv ***
`timescale 1ns/1ps
module event_source_model
(
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       fire,
  input  wire logic [3:0] fire_code,
  input  wire logic       conv_start,
  input  wire logic [9:0] next_data,
  output logic      [8:0] flags,
  output logic            stage0_ev,
  output logic            stage2_ev,
  output logic            conv_done,
  output logic      [9:0] conv_data
);
  // ****************************************************************
  // Event flags, stage events and analog converter
  // ****************************************************************
  int hold_q;
  int busy_q;

  always @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      flags     <= '0;
      stage0_ev <= 1'b0;
      stage2_ev <= 1'b0;
      conv_done <= 1'b0;
      conv_data <= 10'h155;
      hold_q    <= 0;
      busy_q    <= 0;
    end
    else
    begin
      stage0_ev <= 1'b0;
      stage2_ev <= 1'b0;
      if (hold_q > 0)
        hold_q <= hold_q - 1;
      else
        flags <= '0;
      if (fire)
      begin
        hold_q <= 2;
        case (fire_code)
          4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: flags <= 9'h001 << (fire_code - 4'h1);
          4'hb:    flags <= 9'h080;
          4'hc:    flags <= 9'h100;
          4'h8:    stage0_ev <= 1'b1;
          4'ha:    stage2_ev <= 1'b1;
          // Unknown code: every source fires at once
          default:
          begin
            flags     <= 9'h1ff;
            stage0_ev <= 1'b1;
            stage2_ev <= 1'b1;
          end
        endcase
      end
      // Data are junk outside the done cycle
      if (conv_start)
        busy_q <= 8;
      else if (busy_q > 0)
        busy_q <= busy_q - 1;
      conv_done <= (busy_q == 1);
      conv_data <= (busy_q == 1) ? next_data : ~conv_data;
    end
  end
endmodule // event_source_model

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import adc_ctrl_pkg::*;
  logic       ref_clk, reset_n, reg_wr, reg_rd, irq_ack, amplified_channel, fire;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rv;
  logic [3:0] fire_code;
  logic [9:0] next_data, conv_data;
  logic [8:0] flags;
  logic       stage0_ev, stage2_ev, conv_done, conv_start, converter_clk;
  logic       high_speed_conversion, conversion_irq;
  int         fail_count = 0, n_compared = 0, start_count = 0, cycles = 0;
  int         n0, c, a, per;

  // ****************************************************************
  // Clock, design and partner
  // ****************************************************************
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  adc_trigger_and_result_control i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq_ack(irq_ack), .amplified_channel(amplified_channel),
    .comp0_flag(flags[0]), .ext_int0_flag(flags[1]), .t0_compare_flag(flags[2]),
    .t0_overflow_flag(flags[3]), .t1_compare_b_flag(flags[4]), .t1_overflow_flag(flags[5]),
    .t1_capture_flag(flags[6]), .comp1_flag(flags[7]), .comp2_flag(flags[8]),
    .stage0_async_event(stage0_ev), .stage2_async_event(stage2_ev), .conv_done(conv_done),
    .conv_data(conv_data), .conv_start(conv_start), .converter_clk(converter_clk),
    .high_speed_conversion(high_speed_conversion), .conversion_irq(conversion_irq));

  event_source_model i_src (.ref_clk(ref_clk), .reset_n(reset_n), .fire(fire),
    .fire_code(fire_code), .conv_start(conv_start), .next_data(next_data), .flags(flags),
    .stage0_ev(stage0_ev), .stage2_ev(stage2_ev), .conv_done(conv_done),
    .conv_data(conv_data));

  always @(posedge ref_clk)
  begin
    if (reset_n && conv_start === 1'b1)
      start_count++;
    cycles++;
    if (cycles == 20000)
    begin
      $display("[FAIL] %0t timeout", $time);
      fail_count++;
      give_verdict();
    end
  end

  // ****************************************************************
  // Bus tasks and compares
  // ****************************************************************
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %0t value %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_cnt(input int g, input int e);
    n_compared++;
    if (g != e)
    begin
      fail_count++;
      $display("[FAIL] %0t count %0d expected %0d", $time, g, e);
    end
  endtask

  task automatic wr(input logic [2:0] ad, input logic [7:0] d);
    reg_addr  <= ad;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
  endtask

  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic rdchk(input logic [2:0] ad, input logic [7:0] e);
    reg_addr <= ad;
    reg_wr   <= 1'b0;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
    chk8(rv, e);
    @(posedge ref_clk);
  endtask

  task automatic fire_ev(input logic [3:0] cd);
    fire_code <= cd;
    fire      <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
  endtask

  task automatic settle();
    idle(1);
    for (int i = 0; i < 60 && conv_done !== 1'b1; i++)
      @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic measure(output int n);
    logic p;
    n = 0;
    #1;
    do
    begin
      p = converter_clk;
      @(posedge ref_clk);
      #1;
      n++;
    end while (!(p === 1'b0 && converter_clk === 1'b1) && n < 300);
  endtask

  function automatic int trig_exp(input int amp, input int cd);
    if (amp != 0)
      return int'(cd == 8 || cd == 10);
    return int'(!(cd == 9 || cd > 12));
  endfunction

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    {reset_n, reg_wr, reg_rd, irq_ack, amplified_channel, fire} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    fire_code = '0;
    next_data = 10'h270;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    wr(3'h5, 8'hff);
    for (a = 0; a < 6; a++)
      rdchk(a[2:0], 8'h00);
    wr(3'h1, 8'hff);
    idle(1);
    chk8({7'h0, high_speed_conversion}, 8'h01);
    rdchk(3'h1, 8'h8f);
    wr(3'h1, 8'h00);
    idle(1);
    chk8({7'h0, high_speed_conversion}, 8'h00);
    $display("registers and speed done");
    for (c = 0; c < 8; c++)
    begin
      wr(3'h0, c[7:0]);
      idle(1);
      measure(per);
      measure(per);
      // Let the measured high phase finish before the divider changes, for codes up to 3 (divide by eight)
      idle(4);
      chk_cnt(per, (c < 2) ? 2 : (1 << c));
    end
    $display("divider done");
    wr(3'h0, 8'hc8);
    wr(3'h0, 8'h88);
    rdchk(3'h0, 8'hc8);
    settle();
    rdchk(3'h0, 8'h98);
    chk8({7'h0, conversion_irq}, 8'h01);
    chk_cnt(start_count, 1);
    wr(3'h0, 8'h88);
    rdchk(3'h0, 8'h98);
    irq_ack <= 1'b1;
    @(posedge ref_clk);
    irq_ack <= 1'b0;
    rdchk(3'h0, 8'h88);
    chk8({7'h0, conversion_irq}, 8'h00);
    rdchk(3'h2, 8'h70);
    rdchk(3'h3, 8'h02);
    wr(3'h4, 8'h20);
    rdchk(3'h3, 8'h9c);
    rdchk(3'h2, 8'h00);
    rdchk(3'h3, 8'h9c);
    wr(3'h4, 8'h00);
    rdchk(3'h2, 8'h70);
    next_data <= 10'h029;
    wr(3'h0, 8'hc8);
    settle();
    rdchk(3'h2, 8'h70);
    rdchk(3'h0, 8'h88);
    rdchk(3'h3, 8'h02);
    wr(3'h4, 8'h20);
    wr(3'h0, 8'hc8);
    settle();
    rdchk(3'h3, 8'h0a);
    wr(3'h0, 8'h98);
    rdchk(3'h0, 8'h88);
    wr(3'h4, 8'h00);
    idle(1);
    $display("single conversion and result done");
    for (a = 0; a < 2; a++)
    begin
      amplified_channel <= a[0];
      for (c = 1; c < 16; c++)
      begin
        wr(3'h1, c[7:0]);
        wr(3'h0, 8'ha0);
        idle(1);
        n0 = start_count;
        fire_ev(c[3:0]);
        idle(16);
        chk_cnt(start_count - n0, trig_exp(a, c));
      end
    end
    rdchk(3'h0, 8'hb0);
    chk8({7'h0, conversion_irq}, 8'h00);
    amplified_channel <= 1'b0;
    wr(3'h1, 8'h08);
    idle(1);
    n0 = start_count;
    fire_ev(4'h8);
    idle(2);
    fire_ev(4'h8);
    idle(20);
    chk_cnt(start_count - n0, 1);
    wr(3'h0, 8'h80);
    wr(3'h1, 8'h01);
    idle(1);
    n0 = start_count;
    fire_ev(4'h1);
    idle(16);
    chk_cnt(start_count - n0, 0);
    $display("trigger sources done");
    wr(3'h1, 8'h00);
    n0 = start_count;
    wr(3'h0, 8'he0);
    idle(40);
    chk_cnt(int'(start_count - n0 >= 3), 1);
    wr(3'h0, 8'h80);
    idle(20);
    n0 = start_count;
    idle(20);
    chk_cnt(start_count - n0, 0);
    $display("free running done");
    give_verdict();
  end
endmodule // tb_top
